//--- core/gpp_pkg.sv
// constants for the general purpose port block: register offsets,
// reset values, field layout and bus widths.
// assumes the special register space is byte wide with 8-bit addresses.
package gpp_pkg;

  localparam int NUM_PORTS = 4;
  localparam int PORT_W = 8;
  localparam int PIN_W = NUM_PORTS * PORT_W;

  // byte offsets in the special register space
  localparam logic [7:0] ADDR_PORT0_DATA = 8'h80;
  localparam logic [7:0] ADDR_PORT1_DATA = 8'h90;
  localparam logic [7:0] ADDR_PORT2_DATA = 8'hA0;
  localparam logic [7:0] ADDR_PORT3_DATA = 8'hB0;
  localparam logic [7:0] ADDR_PORT0_OUTPUT_MODE = 8'hA4;
  localparam logic [7:0] ADDR_PORT1_OUTPUT_MODE = 8'hA5;
  localparam logic [7:0] ADDR_PORT2_OUTPUT_MODE = 8'hA6;
  localparam logic [7:0] ADDR_PORT3_OUTPUT_MODE = 8'hA7;
  localparam logic [7:0] ADDR_PORT0_SKIP_MASK = 8'hD4;
  localparam logic [7:0] ADDR_PORT1_SKIP_MASK = 8'hD5;
  localparam logic [7:0] ADDR_PORT2_SKIP_MASK = 8'hD6;
  localparam logic [7:0] ADDR_PORT0_INPUT_MODE = 8'hF1;
  localparam logic [7:0] ADDR_PORT1_INPUT_MODE = 8'hF2;
  localparam logic [7:0] ADDR_PORT2_INPUT_MODE = 8'hF3;
  localparam logic [7:0] ADDR_PORT3_INPUT_MODE = 8'hF4;

  // bit addresses: high five bits pick the port, low three the bit
  localparam int BIT_SEL_LSB = 3;

  // reset values
  localparam logic [7:0] RST_DATA = 8'hFF;
  localparam logic [7:0] RST_OUTPUT_MODE = 8'h00;
  localparam logic [7:0] RST_SKIP_MASK = 8'h00;
  localparam logic [7:0] RST_INPUT_MODE = 8'hFF;

  // port 3 has only pins 4..0 in its mode registers
  localparam logic [7:0] PORT3_MODE_MASK = 8'h1F;
  localparam logic [1:0] PORT3 = 2'h3;

  // register kinds found by the address decoder
  typedef enum logic [2:0] {
    GPP_NONE, GPP_DATA, GPP_IN_MODE, GPP_OUT_MODE, GPP_SKIP
  } gpp_kind_t;

endpackage : gpp_pkg

//--- core/gpp_port_io.sv
// four 8-bit general purpose ports: data latches, input mode, output
// mode, skip masks and pin driver control.
// assumes the core's special register port (byte and bit access) and the
// crossbar sit on core_clk; pin levels arrive asynchronously.
`timescale 1ns/10ps

// Behaviour
// R01: a pin not taken by the crossbar or analog use is plain I/O from its latch.
// R02: each port data register can be accessed as a byte or per bit.
// R03: a data write stores the byte in a latch held until the next write.
// R04: an ordinary data read returns pin levels, even for crossbar pins.
// R05: read-modify-write reads return the latch, not the pins.
// R06: the latch reaches a pin only where the crossbar leaves it as port I/O.
// R07: a 0 drives low; a 1 drives high in push-pull, floats in open-drain.
// R08: a data bit whose pin is analog always reads 1.
// R09: a data bit whose pin is digital reads the pin level.
// R10: input mode 0 is analog, 1 digital; analog kills pullup, driver, receiver.
// R11: output mode 0 is open-drain, 1 is push-pull.
// R12: output mode is ignored while the pin's input mode is analog.
// R13: pins carrying the two-wire serial bus are always open-drain.
// R14: software skips analog and dedicated pins; skip bit 1 skips the pin.
// R15: port 3 mode bits 7..5 read 000b and ignore writes.
// R16: with the crossbar disabled all drivers are off, pins are inputs.
// R17: with pullups enabled, open-drain digital pins get a pullup unless low.
module gpp_port_io
  import gpp_pkg::*;
(
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // byte access to special registers
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic sfr_rmw,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  // bit access to port data registers
  input wire logic [7:0] bit_addr,
  input wire logic bit_wr,
  input wire logic bit_rd,
  input wire logic bit_rmw,
  input wire logic bit_wdata,
  output logic bit_rdata,
  // crossbar controls and routed peripheral signals
  input wire logic crossbar_enable_bit,
  input wire logic weak_pullup_disable_bit,
  input wire logic [PIN_W-1:0] xbar_assign,
  input wire logic [PIN_W-1:0] xbar_value,
  input wire logic [PIN_W-1:0] xbar_serial_bus,
  output logic [PIN_W-1:0] crossbar_skip_mask,
  // pins
  input wire logic [PIN_W-1:0] pin_in,
  output logic [PIN_W-1:0] pin_out,
  output logic [PIN_W-1:0] pin_oe_n,
  output logic [PIN_W-1:0] pin_pullup,
  output logic [PIN_W-1:0] pin_analog
);

  logic [PIN_W-1:0] data_latch;
  logic [PIN_W-1:0] input_mode_reg;
  logic [PIN_W-1:0] output_mode_reg;
  logic [PIN_W-1:0] skip_reg;
  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_sync;

  logic [2:0] byte_kind;
  logic [1:0] byte_port;
  logic bit_hit;
  logic [1:0] bit_port;
  logic [2:0] bit_idx;

  logic [PIN_W-1:0] next_pin_out;
  logic [PIN_W-1:0] next_pin_oe_n;
  logic [PIN_W-1:0] next_pin_pullup;
  logic [PIN_W-1:0] next_pin_analog;
  logic [7:0] next_sfr_rdata;
  logic [7:0] byte_view;
  logic [7:0] bit_view;
  logic data_wr_en;
  logic bit_wr_en;
  logic in_mode_wr_en;
  logic out_mode_wr_en;
  logic skip_wr_en;

  // address to {kind, port}
  function automatic logic [4:0] decode(input logic [7:0] a);
    case (a)
      ADDR_PORT0_DATA: decode = {GPP_DATA, 2'h0};
      ADDR_PORT1_DATA: decode = {GPP_DATA, 2'h1};
      ADDR_PORT2_DATA: decode = {GPP_DATA, 2'h2};
      ADDR_PORT3_DATA: decode = {GPP_DATA, 2'h3};
      ADDR_PORT0_INPUT_MODE: decode = {GPP_IN_MODE, 2'h0};
      ADDR_PORT1_INPUT_MODE: decode = {GPP_IN_MODE, 2'h1};
      ADDR_PORT2_INPUT_MODE: decode = {GPP_IN_MODE, 2'h2};
      ADDR_PORT3_INPUT_MODE: decode = {GPP_IN_MODE, 2'h3};
      ADDR_PORT0_OUTPUT_MODE: decode = {GPP_OUT_MODE, 2'h0};
      ADDR_PORT1_OUTPUT_MODE: decode = {GPP_OUT_MODE, 2'h1};
      ADDR_PORT2_OUTPUT_MODE: decode = {GPP_OUT_MODE, 2'h2};
      ADDR_PORT3_OUTPUT_MODE: decode = {GPP_OUT_MODE, 2'h3};
      ADDR_PORT0_SKIP_MASK: decode = {GPP_SKIP, 2'h0};
      ADDR_PORT1_SKIP_MASK: decode = {GPP_SKIP, 2'h1};
      ADDR_PORT2_SKIP_MASK: decode = {GPP_SKIP, 2'h2};
      default: decode = {GPP_NONE, 2'h0};
    endcase
  endfunction : decode

  // bit address hits a data port when its high bits match a port base
  function automatic logic [2:0] bit_decode(input logic [7:0] a);
    logic [4:0] hi;
    hi = a[7:BIT_SEL_LSB];
    if (hi == ADDR_PORT0_DATA[7:BIT_SEL_LSB]) begin
      bit_decode = {1'b1, 2'h0};
    end else if (hi == ADDR_PORT1_DATA[7:BIT_SEL_LSB]) begin
      bit_decode = {1'b1, 2'h1};
    end else if (hi == ADDR_PORT2_DATA[7:BIT_SEL_LSB]) begin
      bit_decode = {1'b1, 2'h2};
    end else if (hi == ADDR_PORT3_DATA[7:BIT_SEL_LSB]) begin
      bit_decode = {1'b1, 2'h3};
    end else begin
      bit_decode = 3'h0;
    end
  endfunction : bit_decode

  // data read: latch for read-modify-write, pins otherwise
  function automatic logic [7:0] data_view(
    input logic [1:0] p,
    input logic rmw,
    input logic [PIN_W-1:0] latch,
    input logic [PIN_W-1:0] pins,
    input logic [PIN_W-1:0] imode
  );
    if (rmw) begin
      data_view = latch[p*PORT_W +: PORT_W]; // R05
    end else begin
      // analog pins read 1, digital pins read their level
      data_view = pins[p*PORT_W +: PORT_W]
                | ~imode[p*PORT_W +: PORT_W]; // R04 R08 R09
    end
  endfunction : data_view

  // port 3 mode registers keep only pins 4..0
  function automatic logic [7:0] mode_mask(input logic [1:0] p);
    mode_mask = (p == PORT3) ? PORT3_MODE_MASK : 8'hFF; // R15
  endfunction : mode_mask

  assign {byte_kind, byte_port} = decode(sfr_addr);
  assign {bit_hit, bit_port} = bit_decode(bit_addr);
  assign bit_idx = bit_addr[BIT_SEL_LSB-1:0];

  // one latch write per cycle: a byte data write wins over a bit write
  assign data_wr_en = sfr_wr && byte_kind == GPP_DATA;
  assign bit_wr_en = bit_wr && bit_hit && !data_wr_en;
  assign in_mode_wr_en = sfr_wr && byte_kind == GPP_IN_MODE;
  assign out_mode_wr_en = sfr_wr && byte_kind == GPP_OUT_MODE;
  assign skip_wr_en = sfr_wr && byte_kind == GPP_SKIP;
  assign byte_view = data_view(byte_port, sfr_rmw, data_latch,
                               pin_sync, input_mode_reg);
  assign bit_view = data_view(bit_port, bit_rmw, data_latch,
                              pin_sync, input_mode_reg);

  // pins are asynchronous: two flops before any use
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else if (ce) begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // output latches, byte and bit writes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      data_latch <= {NUM_PORTS{RST_DATA}};
    end else if (ce) begin
      if (data_wr_en) begin
        data_latch[byte_port*PORT_W +: PORT_W] <= sfr_wdata; // R03
      end else if (bit_wr_en) begin
        data_latch[bit_port*PORT_W + bit_idx] <= bit_wdata; // R02
      end
    end
  end

  // input mode registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      // port 3 bits 7..5 have no pin and read 0 from reset on
      input_mode_reg <= {RST_INPUT_MODE & PORT3_MODE_MASK,
                         {(NUM_PORTS-1){RST_INPUT_MODE}}}; // R15
    end else if (ce && in_mode_wr_en) begin
      input_mode_reg[byte_port*PORT_W +: PORT_W] <=
        sfr_wdata & mode_mask(byte_port); // R10 R15
    end
  end

  // output mode registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      output_mode_reg <= {NUM_PORTS{RST_OUTPUT_MODE}};
    end else if (ce && out_mode_wr_en) begin
      output_mode_reg[byte_port*PORT_W +: PORT_W] <=
        sfr_wdata & mode_mask(byte_port); // R11 R15
    end
  end

  // skip masks feed the crossbar's pin walk
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      skip_reg <= {NUM_PORTS{RST_SKIP_MASK}};
    end else if (ce && skip_wr_en) begin
      skip_reg[byte_port*PORT_W +: PORT_W] <= sfr_wdata; // R14
    end
  end

  // byte read data
  always_comb begin
    case (byte_kind)
      GPP_DATA: begin
        next_sfr_rdata = byte_view; // R04 R05
      end
      GPP_IN_MODE: begin
        next_sfr_rdata = input_mode_reg[byte_port*PORT_W +: PORT_W];
      end
      GPP_OUT_MODE: begin
        next_sfr_rdata = output_mode_reg[byte_port*PORT_W +: PORT_W];
      end
      GPP_SKIP: begin
        next_sfr_rdata = skip_reg[byte_port*PORT_W +: PORT_W];
      end
      default: begin
        next_sfr_rdata = 8'h00;
      end
    endcase
  end

  // read answers stand until the next read
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else if (ce && sfr_rd) begin
      sfr_rdata <= next_sfr_rdata;
    end
  end

  // hit flag tells software whether the address exists at all
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sfr_hit <= 1'b0;
    end else if (ce && sfr_rd) begin
      sfr_hit <= (byte_kind != GPP_NONE);
    end
  end

  // unmapped bit addresses read 0
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bit_rdata <= 1'b0;
    end else if (ce && bit_rd) begin
      bit_rdata <= bit_hit && bit_view[bit_idx]; // R02
    end
  end

  // pin driver decision per pin
  always_comb begin
    for (int i = 0; i < PIN_W; i++) begin
      logic digital;
      logic val;
      logic open_drain;
      logic drive_low;
      logic drive_high;
      digital = input_mode_reg[i]; // R10
      // crossbar pins take the peripheral value, others the latch
      val = xbar_assign[i] ? xbar_value[i] : data_latch[i]; // R01 R06
      // analog pins have no output mode at all
      open_drain = ~output_mode_reg[i] | xbar_serial_bus[i]; // R11 R12 R13
      drive_low = crossbar_enable_bit & digital & ~val; // R07 R16
      drive_high = crossbar_enable_bit & digital & val
                 & ~open_drain; // R07 R16
      next_pin_out[i] = val & drive_high;
      next_pin_oe_n[i] = ~(drive_low | drive_high);
      // pullup off while driving low to save current
      next_pin_pullup[i] = ~weak_pullup_disable_bit & digital
                         & open_drain & ~drive_low; // R17
      next_pin_analog[i] = ~digital; // R10
    end
  end

  // pin controls, one register per concern
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_out <= '0;
    end else if (ce) begin
      pin_out <= next_pin_out;
    end
  end

  // drivers stay off through reset so the board sees inputs only
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_oe_n <= '1;
    end else if (ce) begin
      pin_oe_n <= next_pin_oe_n;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_pullup <= '0;
    end else if (ce) begin
      pin_pullup <= next_pin_pullup;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_analog <= '0;
    end else if (ce) begin
      pin_analog <= next_pin_analog;
    end
  end

  // crossbar sees a skip mask one cycle after its write
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      crossbar_skip_mask <= '0;
    end else if (ce) begin
      crossbar_skip_mask <= skip_reg;
    end
  end

endmodule : gpp_port_io

//--- tb/gpp_port_io_chk.sv
// checker for the port block: driver, pullup and read relations
// bound to gpp_port_io, sees its ports only
`timescale 1ns/10ps
module gpp_port_io_chk
  import gpp_pkg::*;
(
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // register reads
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_hit,
  // crossbar and pins
  input wire logic crossbar_enable_bit,
  input wire logic weak_pullup_disable_bit,
  input wire logic [PIN_W-1:0] xbar_assign,
  input wire logic [PIN_W-1:0] xbar_value,
  input wire logic [PIN_W-1:0] xbar_serial_bus,
  input wire logic [PIN_W-1:0] pin_out,
  input wire logic [PIN_W-1:0] pin_oe_n,
  input wire logic [PIN_W-1:0] pin_pullup,
  input wire logic [PIN_W-1:0] pin_analog
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_xbar_off_drv: assert property (ce && !crossbar_enable_bit |=> &pin_oe_n)
    else $error("driver on with crossbar off");
  a_analog_quiet: assert property ((pin_analog & (~pin_oe_n | pin_pullup)) == '0)
    else $error("analog pin driven or pulled up");
  a_low_no_pull: assert property ((~pin_oe_n & ~pin_out & pin_pullup) == '0)
    else $error("pullup on a pin driven low");
  a_high_no_pull: assert property ((~pin_oe_n & pin_out & pin_pullup) == '0)
    else $error("pullup on a push-pull pin");
  a_wpud_pull_off: assert property (ce && weak_pullup_disable_bit |=> pin_pullup == '0)
    else $error("pullup while disabled");
  a_serial_open_drain: assert property (ce |=>
    (~pin_oe_n & pin_out & $past(xbar_serial_bus)) == '0)
    else $error("serial bus pin driven high");
  a_assign_value: assert property (ce |=>
    (~pin_oe_n & $past(xbar_assign) & (pin_out ^ $past(xbar_value))) == '0)
    else $error("assigned pin shows wrong value");
  a_unmapped_read: assert property (ce && sfr_rd && sfr_addr == 8'h00
    |=> !sfr_hit && sfr_rdata == 8'h00)
    else $error("unmapped read answered");
  a_mapped_hit: assert property (ce && sfr_rd && sfr_addr == 8'h90 |=> sfr_hit)
    else $error("mapped read missed");
  c_drive: cover property (crossbar_enable_bit && |(~pin_oe_n));
  c_serial: cover property (|(xbar_serial_bus & xbar_assign));
  c_unmapped: cover property (sfr_rd && sfr_addr == 8'h00);
endmodule : gpp_port_io_chk

bind gpp_port_io gpp_port_io_chk i_gpp_port_io_chk (.*);

//--- tb/gpp_pin_model.sv
// board side of the pins: external drivers, pullups, floating lines
// ext_en counts only where the block is not driving; the block's driver wins
`timescale 1ns/10ps
module gpp_pin_model
  import gpp_pkg::*;
(
  // clock
  input wire logic core_clk,
  // block side
  input wire logic [PIN_W-1:0] pin_out,
  input wire logic [PIN_W-1:0] pin_oe_n,
  input wire logic [PIN_W-1:0] pin_pullup,
  // board drivers and resolved level
  input wire logic [PIN_W-1:0] ext_val,
  input wire logic [PIN_W-1:0] ext_en,
  output logic [PIN_W-1:0] pin_in
);
  // an undriven line wanders so a stale value cannot pass
  logic [PIN_W-1:0] flt = '0;
  always @(posedge core_clk) flt <= ~flt;
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
    | (pin_oe_n & ~ext_en & (pin_pullup | flt));
endmodule : gpp_pin_model

//--- tb/general_purpose_port_io_bench.sv
// random and corner tests of the port block against the board model
// assumes gpp_pkg compiled first and the checker bound to the block
`timescale 1ns/10ps
module general_purpose_port_io_bench;
  import gpp_pkg::*;
  logic core_clk, rst, ce, sfr_wr, sfr_rd, sfr_rmw, sfr_hit, xen, wpud;
  logic bit_wr, bit_rd, bit_rmw, bit_wdata, bit_rdata;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, bit_addr, d, m;
  logic [PIN_W-1:0] asg, val, ser, skip, pin_in, pin_out, pin_oe_n;
  logic [PIN_W-1:0] pin_pullup, pin_analog, ext_val, ext_en, pv;
  logic [PIN_W-1:0] e_oe_n, e_out, e_pu, lat, im, om;
  logic [7:0] da [4] = '{8'h80, 8'h90, 8'hA0, 8'hB0};
  logic [7:0] ia [4] = '{8'hF1, 8'hF2, 8'hF3, 8'hF4};
  logic [7:0] oa [4] = '{8'hA4, 8'hA5, 8'hA6, 8'hA7};
  logic [31:0] seed = 32'h38;
  int error_cnt = 0;
  int total_checks = 0;

  gpp_port_io i_gpp_port_io (.*, .crossbar_enable_bit(xen),
    .weak_pullup_disable_bit(wpud), .xbar_assign(asg), .xbar_value(val),
    .xbar_serial_bus(ser), .crossbar_skip_mask(skip));
  gpp_pin_model i_gpp_pin_model (.*);

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // serial bus pins count as open-drain for the pullup too
  function automatic void expect_pins();
    logic [PIN_W-1:0] v, od;
    v = (asg & val) | (~asg & lat);
    od = ~om | ser;
    e_oe_n = ~(im & {PIN_W{xen}} & (~v | ~od));
    e_out = ~e_oe_n & v;
    e_pu = {PIN_W{!wpud}} & im & od & ~(~e_oe_n & ~e_out);
  endfunction : expect_pins

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_wdata = w;
    sfr_wr = 1'b1;
    @(negedge core_clk);
    sfr_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic r, input logic [7:0] e);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_rmw = r;
    sfr_rd = 1'b1;
    @(negedge core_clk);
    sfr_rd = 1'b0;
    chk(sfr_rdata, e);
  endtask : rd

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  initial begin
    #100000;
    error_cnt++;
    conclude();
  end

  initial begin
    {rst, ce, sfr_wr, sfr_rd, sfr_rmw, bit_wr, bit_rd, bit_rmw} = 8'hC0;
    {bit_wdata, xen, wpud, sfr_addr, sfr_wdata, bit_addr} = '0;
    {asg, val, ser, ext_val, ext_en, om} = '0;
    lat = '1;
    im = 32'h1FFFFFFF;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    // let pullups settle and pass the two synchroniser flops
    repeat (4) @(negedge core_clk);
    for (int p = 0; p < 4; p++) begin
      rd(da[p], 1'b0, 8'hFF);
      rd(ia[p], 1'b0, im[8*p+:8]);
      rd(oa[p], 1'b0, 8'h00);
      if (p < 3) rd(8'(8'hD4 + p), 1'b0, 8'h00);
    end
    rd(8'h00, 1'b0, 8'h00);
    chk(sfr_hit, 1'b0);
    ext_en = '1;
    repeat (20) begin
      xen = rnd() % 4 != 0;
      wpud = rnd() % 4 == 0;
      asg = rnd() & rnd();
      val = rnd();
      ser = rnd() & rnd();
      ext_val = rnd();
      for (int p = 0; p < 4; p++) begin
        m = (p == 3) ? 8'h1F : 8'hFF;
        d = 8'(rnd());
        wr(da[p], d);
        lat[8*p+:8] = d;
        d = 8'(rnd() | rnd());
        wr(ia[p], d);
        im[8*p+:8] = d & m;
        d = 8'(rnd());
        wr(oa[p], d);
        om[8*p+:8] = d & m;
      end
      repeat (3) @(negedge core_clk);
      expect_pins();
      chk(pin_oe_n, e_oe_n);
      chk(pin_out, e_out);
      chk(pin_pullup, e_pu);
      chk(pin_analog, ~im);
      pv = (~e_oe_n & e_out) | (e_oe_n & ext_val) | ~im;
      for (int p = 0; p < 4; p++) begin
        rd(da[p], 1'b0, pv[8*p+:8]);
        rd(da[p], 1'b1, lat[8*p+:8]);
        rd(ia[p], 1'b0, im[8*p+:8]);
        rd(oa[p], 1'b0, om[8*p+:8]);
      end
    end
    for (int p = 0; p < 3; p++) begin
      d = 8'(rnd());
      wr(8'(8'hD4 + p), d);
      repeat (2) @(negedge core_clk);
      chk(skip[8*p+:8], d);
    end
    @(negedge core_clk);
    bit_addr = 8'h93;
    bit_wdata = ~lat[11];
    bit_wr = 1'b1;
    @(negedge core_clk);
    bit_wr = 1'b0;
    lat[11] = ~lat[11];
    bit_rmw = 1'b1;
    bit_rd = 1'b1;
    @(negedge core_clk);
    bit_rd = 1'b0;
    chk(bit_rdata, lat[11]);
    rd(8'h90, 1'b1, lat[15:8]);
    // a write while the clock enable is low must be lost
    ce = 1'b0;
    wr(8'h90, ~lat[15:8]);
    ce = 1'b1;
    rd(8'h90, 1'b1, lat[15:8]);
    conclude();
  end
endmodule : general_purpose_port_io_bench
